//--- design/wdog_pkg.sv
// Package: constants, states and carrier structs for the output watchdog block.
// Assumes a 200 MHz clock and a synchronous active-high reset.
package wdog_pkg;
  localparam int unsigned clock_hz = 200000000;
  localparam int unsigned tick_ms = 1;
  localparam int unsigned tick_cycles = clock_hz / 1000 * tick_ms;
  localparam int unsigned flash_half_ms = 500;
  localparam logic [15:0] timeout_reset = 16'h0000;
  localparam logic [15:0] timeout_min_ms = 16'h00c8;
  localparam logic [15:0] timeout_max_ms = 16'hfde8;
  localparam logic [1:0] subst_low = 2'h0;
  localparam logic [1:0] subst_high = 2'h1;
  localparam logic [1:0] subst_hold = 2'h2;
  localparam logic [7:0] sw_remote = 8'h00;
  localparam logic [7:0] sw_manual_last = 8'h50;
  localparam logic [7:0] sw_dhcp_first = 8'h51;
  localparam logic [7:0] sw_dhcp_last = 8'hff;
  localparam logic [7:0] sw_static = 8'h0a;
  localparam logic [7:0] sw_ip_reset = 8'h0e;
  localparam logic [7:0] sw_factory = 8'h0f;
  localparam int unsigned out_count = 4;
  localparam int unsigned in_count = 8;
  localparam int unsigned port_count = 2;

  // Two-bit colour code for a bicolour indicator
  localparam logic [1:0] led_off = 2'h0;
  localparam logic [1:0] led_green = 2'h1;
  localparam logic [1:0] led_yellow = 2'h2;
  localparam logic [1:0] led_red = 2'h3;

  typedef enum logic [2:0] {
    wd_idle = 3'b001,
    wd_armed = 3'b010,
    wd_run = 3'b100
  } wd_state_type;

  typedef struct packed {
    logic ready;
    logic fw_update;
    logic supply_fault;
    logic temp_fault;
    logic sensor_present;
    logic sensor_overload;
    logic actuator_present;
    logic addr_request;
    logic addr_invalid;
    logic addr_conflict;
    logic conn_possible;
    logic conn_open;
  } device_status_type;

  typedef struct packed {
    logic [1:0] ready_led;
    logic [1:0] net_led;
    logic [1:0] sensor_supply_indicator;
    logic actuator_supply_indicator;
    logic [port_count-1:0] port_link_indicator;
    logic [port_count-1:0] port_activity_indicator;
    logic [in_count-1:0] in_led;
    logic [2*out_count-1:0] out_led;
  } led_type;
endpackage

//--- design/ms_tick.sv
// Prescaler: one-cycle pulse every millisecond, plus a slow flash phase.
// Assumes the 200 MHz system clock.
`timescale 1ns/1ps
module ms_tick (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset, high
  output logic tick, // One-cycle millisecond pulse
  output logic flash // Indicator flash phase
);
  typedef struct packed {
    logic [17:0] div;
    logic [9:0] ms;
    logic tick;
    logic flash;
  } tick_state_type;

  tick_state_type state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.div == 18'(wdog_pkg::tick_cycles - 1)) begin
      state_next.div = '0;
      state_next.tick = 1'b1;
      if (state_reg.ms == 10'(wdog_pkg::flash_half_ms - 1)) begin
        state_next.ms = '0;
        state_next.flash = ~state_reg.flash;
      end else begin
        state_next.ms = state_reg.ms + 10'h001;
      end
    end else begin
      state_next.div = state_reg.div + 18'h00001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
  assign flash = state_reg.flash;
endmodule

//--- design/output_watchdog.sv
// Output process data watchdog, substitute values and status indicators.
// Assumes a network core that signals output writes, reads and link events.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module output_watchdog (
  input wire logic clock, // System clock, 200 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic [7:0] switch_code, // Rotary switch code, two digits
  input wire logic factory_done, // Settings restore finished
  input wire logic cfg_write, // Configuration write strobe
  input wire logic [1:0] cfg_addr, // 0 timeout, 1 substitute, 2 command
  input wire logic [15:0] cfg_data, // Configuration write data
  input wire logic cfg_read, // Configuration read strobe
  output logic [15:0] cfg_rdata, // Read data, one cycle later
  input wire logic auto_ack, // High selects automatic acknowledge
  input wire logic out_write, // Output process data write pulse
  input wire logic [3:0] out_data, // Output process data
  input wire logic out_read, // Any process data read pulse
  input wire logic conn_timeout, // Connection monitor expired pulse
  input wire logic addr_write_req, // Remote tool address change request
  input wire logic [3:0] out_fault, // Output short or overload
  input wire logic [7:0] in_state, // Input levels
  input wire logic [1:0] port_link, // Link present per port
  input wire logic [1:0] port_activity, // Traffic per port
  input wire wdog_pkg::device_status_type status, // Device condition flags
  output logic [3:0] out_drive, // Physical output drive
  output logic net_fail, // Network fail state
  output logic conn_allow, // Connections permitted
  output logic addr_clear, // Clear stored address and mask
  output logic settings_restore, // Restore all settings to default
  output logic request_addressing, // Enable request-based addressing
  output logic addr_write_allow, // Remote address change accepted
  output logic keep_settings, // Keep previous settings
  output wdog_pkg::led_type leds // Indicator drive
);
  localparam logic [1:0] cfg_timeout = 2'h0;
  localparam logic [1:0] cfg_subst = 2'h1;
  localparam logic [1:0] cfg_command = 2'h2;
  localparam logic [1:0] cfg_status = 2'h3;
  localparam logic [15:0] cmd_ack = 16'h0001;
  localparam logic [3:0] digit_max = 4'h9;

  typedef struct packed {
    wdog_pkg::wd_state_type wd;
    logic [15:0] timeout;
    logic [15:0] count;
    logic [1:0] subst;
    logic fail;
    logic [3:0] stored;
    logic [3:0] drive;
    logic [15:0] rdata;
    logic [1:0] mode;
    logic mode_taken;
    wdog_pkg::led_type leds;
  } state_type;

  // Mode of the switch caught after reset
  localparam logic [1:0] mode_normal = 2'h0;
  localparam logic [1:0] mode_ip_reset = 2'h1;
  localparam logic [1:0] mode_factory = 2'h2;
  localparam logic [1:0] mode_reserved = 2'h3;

  state_type state_reg, state_next;
  logic tick;
  logic flash;
  logic static_mode_reg;

  ms_tick tick_gen (
    .clock(clock),
    .reset(reset),
    .tick(tick),
    .flash(flash)
  );

  function automatic logic timeout_valid(input logic [15:0] value);
    timeout_valid = (value == wdog_pkg::timeout_reset) ||
      ((value >= wdog_pkg::timeout_min_ms) && (value <= wdog_pkg::timeout_max_ms));
  endfunction

  // Second switch digit above 9 is only legal at the special positions
  function automatic logic digit_ok(input logic [7:0] code);
    digit_ok = code[3:0] <= digit_max;
  endfunction

  function automatic logic [1:0] decode_switch(input logic [7:0] code);
    logic manual;
    logic dhcp;
    manual = digit_ok(code) && (code <= wdog_pkg::sw_manual_last);
    dhcp = digit_ok(code) && (code >= wdog_pkg::sw_dhcp_first) &&
      (code <= wdog_pkg::sw_dhcp_last);
    if (code == wdog_pkg::sw_ip_reset) begin
      decode_switch = mode_ip_reset;
    end else if (code == wdog_pkg::sw_factory) begin
      decode_switch = mode_factory;
    end else if (manual || dhcp || (code == wdog_pkg::sw_static)) begin
      decode_switch = mode_normal;
    end else begin
      // Anything else is reserved: keep old settings, flag it
      decode_switch = mode_reserved;
    end
  endfunction

  function automatic logic [3:0] substitute(input logic [1:0] code, input logic [3:0] last);
    case (code)
      wdog_pkg::subst_low: substitute = '0;
      wdog_pkg::subst_high: substitute = '1;
      wdog_pkg::subst_hold: substitute = last;
      default: substitute = '0;
    endcase
  endfunction

  function automatic logic [1:0] blink(input logic [1:0] colour, input logic phase);
    blink = phase ? colour : wdog_pkg::led_off;
  endfunction

  logic expire;
  logic ack_cmd;
  logic clear_fail;

  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    ack_cmd = cfg_write && (cfg_addr == cfg_command) && (cfg_data == cmd_ack);

    // Switch position sampled once, after reset release
    if (!state_reg.mode_taken) begin
      state_next.mode = decode_switch(switch_code);
      state_next.mode_taken = 1'b1;
    end

    if (cfg_write && cfg_addr == cfg_timeout && timeout_valid(cfg_data)) begin
      // Watchdog cannot be stopped once running; zero only accepted when idle
      if (state_reg.wd == wdog_pkg::wd_idle || cfg_data != wdog_pkg::timeout_reset) begin
        state_next.timeout = cfg_data;
      end
    end
    if (cfg_write && cfg_addr == cfg_subst && cfg_data[15:2] == '0 &&
        cfg_data[1:0] != 2'h3) begin
      state_next.subst = cfg_data[1:0];
    end
    if (cfg_read) begin
      case (cfg_addr)
        cfg_timeout: state_next.rdata = state_reg.timeout;
        cfg_subst: state_next.rdata = {14'h0000, state_reg.subst};
        cfg_status: state_next.rdata = {14'h0000, state_reg.fail, 1'b0};
        default: state_next.rdata = '0;
      endcase
    end

    // Watchdog; reads are not looked at here at all
    expire = 1'b0;
    case (state_reg.wd)
      wdog_pkg::wd_idle: begin
        state_next.count = '0;
        if (state_reg.timeout != wdog_pkg::timeout_reset) begin
          state_next.wd = wdog_pkg::wd_armed;
        end
      end
      wdog_pkg::wd_armed: begin
        if (out_write) begin
          state_next.wd = wdog_pkg::wd_run;
          state_next.count = '0;
        end
      end
      wdog_pkg::wd_run: begin
        if (out_write) begin
          state_next.count = '0;
        end else if (tick) begin
          if (state_reg.count + 16'h0001 >= state_reg.timeout) begin
            expire = 1'b1;
            state_next.count = '0;
            state_next.wd = wdog_pkg::wd_armed;
          end else begin
            state_next.count = state_reg.count + 16'h0001;
          end
        end
      end
      default: state_next.wd = wdog_pkg::wd_idle;
    endcase

    if (out_write) begin
      state_next.stored = out_data;
    end

    // Acknowledge; a new fault in the same cycle wins
    clear_fail = state_reg.fail && ((auto_ack && out_write) || (!auto_ack && ack_cmd));
    if (expire || conn_timeout) begin
      state_next.fail = 1'b1;
    end else if (clear_fail) begin
      state_next.fail = 1'b0;
      if (state_reg.timeout != wdog_pkg::timeout_reset) begin
        state_next.wd = wdog_pkg::wd_run;
        state_next.count = '0;
      end
    end

    if (state_next.fail) begin
      if (!state_reg.fail) begin
        state_next.drive = substitute(state_reg.subst, state_reg.drive);
      end
    end else begin
      state_next.drive = state_next.stored;
    end

    // Ready indicator
    if (!status.ready) begin
      state_next.leds.ready_led = wdog_pkg::led_off;
    end else if (state_reg.mode == mode_reserved) begin
      state_next.leds.ready_led = wdog_pkg::led_red;
    end else if (state_reg.mode == mode_factory && !factory_done) begin
      state_next.leds.ready_led = wdog_pkg::led_off;
    end else if (status.supply_fault || status.temp_fault || status.sensor_overload ||
                 !status.actuator_present) begin
      state_next.leds.ready_led = flash ? wdog_pkg::led_green : wdog_pkg::led_yellow;
    end else if (status.fw_update) begin
      state_next.leds.ready_led = blink(wdog_pkg::led_green, flash);
    end else begin
      state_next.leds.ready_led = wdog_pkg::led_green;
    end

    // Network indicator, blank when not ready, then fail first
    if (!status.ready) begin
      state_next.leds.net_led = wdog_pkg::led_off;
    end else if (state_next.fail) begin
      state_next.leds.net_led = wdog_pkg::led_red;
    end else if (state_reg.mode == mode_ip_reset) begin
      state_next.leds.net_led = wdog_pkg::led_yellow;
    end else if (status.addr_conflict) begin
      state_next.leds.net_led = blink(wdog_pkg::led_red, flash);
    end else if (status.addr_invalid) begin
      state_next.leds.net_led = wdog_pkg::led_yellow;
    end else if (status.addr_request) begin
      state_next.leds.net_led = blink(wdog_pkg::led_yellow, flash);
    end else if (status.conn_open) begin
      state_next.leds.net_led = wdog_pkg::led_green;
    end else if (status.conn_possible) begin
      state_next.leds.net_led = blink(wdog_pkg::led_green, flash);
    end else begin
      state_next.leds.net_led = wdog_pkg::led_off;
    end

    if (status.sensor_overload) begin
      state_next.leds.sensor_supply_indicator = wdog_pkg::led_red;
    end else if (status.sensor_present) begin
      state_next.leds.sensor_supply_indicator = wdog_pkg::led_green;
    end else begin
      state_next.leds.sensor_supply_indicator = wdog_pkg::led_off;
    end
    state_next.leds.actuator_supply_indicator = status.actuator_present;
    state_next.leds.port_link_indicator = port_link;
    state_next.leds.port_activity_indicator = port_activity;
    // Index is byte*8+bit, so channel 0.n sits at bit n
    state_next.leds.in_led = in_state;
    for (int i = 0; i < wdog_pkg::out_count; i++) begin
      if (out_fault[i]) begin
        state_next.leds.out_led[2*i +: 2] = wdog_pkg::led_red;
      end else if (state_next.drive[i]) begin
        state_next.leds.out_led[2*i +: 2] = wdog_pkg::led_yellow;
      end else begin
        state_next.leds.out_led[2*i +: 2] = wdog_pkg::led_off;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.wd <= wdog_pkg::wd_idle;
      state_reg.timeout <= wdog_pkg::timeout_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  // Static position caught once after reset; no async capture of the switch
  always_ff @(posedge clock) begin
    if (reset) begin
      static_mode_reg <= 1'b0;
    end else if (!state_reg.mode_taken) begin
      static_mode_reg <= (switch_code == wdog_pkg::sw_static);
    end
  end

  assign out_drive = state_reg.drive;
  assign net_fail = state_reg.fail;
  assign cfg_rdata = state_reg.rdata;
  assign leds = state_reg.leds;
  // Connections refused until the switch has been read, and in 0E/0F
  assign conn_allow = state_reg.mode_taken && (state_reg.mode == mode_normal ||
    state_reg.mode == mode_reserved);
  assign addr_clear = state_reg.mode_taken && (state_reg.mode == mode_ip_reset ||
    state_reg.mode == mode_factory);
  assign settings_restore = state_reg.mode_taken && state_reg.mode == mode_factory;
  assign request_addressing = state_reg.mode_taken && state_reg.mode != mode_reserved &&
    (state_reg.mode != mode_normal || switch_code == wdog_pkg::sw_remote);
  assign keep_settings = state_reg.mode_taken && state_reg.mode == mode_reserved;
  assign addr_write_allow = addr_write_req && state_reg.mode_taken && !static_mode_reg;
endmodule

//--- sim/output_watchdog_checker.sv
// Checker for the output watchdog block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module output_watchdog_checker (
  input wire logic clock, // System clock
  input wire logic reset, // Sync reset
  input wire logic [7:0] switch_code, // Rotary code
  input wire logic cfg_read, // Read strobe
  input wire logic [1:0] cfg_addr, // Config address
  input wire logic [15:0] cfg_rdata, // Read data
  input wire logic auto_ack, // Auto acknowledge
  input wire logic out_write, // Output write
  input wire logic [3:0] out_data, // Output data
  input wire logic conn_timeout, // Connection expiry
  input wire logic addr_write_req, // Address change request
  input wire logic [3:0] out_fault, // Output faults
  input wire logic [7:0] in_state, // Inputs
  input wire logic [1:0] port_link, // Links
  input wire logic [3:0] out_drive, // Outputs
  input wire logic net_fail, // Fail state
  input wire logic conn_allow, // Connections allowed
  input wire logic addr_clear, // Address clear
  input wire logic addr_write_allow, // Address change accepted
  input wire wdog_pkg::device_status_type status, // Device flags
  input wire wdog_pkg::led_type leds // Indicators
);
  logic [1:0] age_reg;
  logic settled;
  // Checks other than freeze and auto clear wait three edges after reset; mode outputs settle after the first
  always_ff @(posedge clock) begin
    if (reset) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  assign settled = age_reg == 2'h3;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_fail_set; settled && conn_timeout |=> net_fail; endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail not set");
  // Not ready blanks the indicator, so fail only shows while ready
  property p_fail_red;
    settled && net_fail && $past(status.ready) |-> leds.net_led == wdog_pkg::led_red;
  endproperty
  a_fail_red: assert property (p_fail_red) else $error("net not red");
  property p_freeze; net_fail ##1 net_fail |-> $stable(out_drive); endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved in fail");
  property p_auto_clear;
    net_fail && auto_ack && out_write && !conn_timeout |=>
      !net_fail && out_drive == $past(out_data);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto clear missed");
  property p_apply;
    settled && !net_fail && out_write && !conn_timeout |=> out_drive == $past(out_data);
  endproperty
  a_apply: assert property (p_apply) else $error("write not applied");
  property p_status;
    settled && cfg_read && cfg_addr == 2'h3 |=> cfg_rdata[1] == $past(net_fail);
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong");
  property p_addr_lock;
    settled |-> addr_write_allow == (addr_write_req && switch_code != wdog_pkg::sw_static);
  endproperty
  a_addr_lock: assert property (p_addr_lock) else $error("address lock wrong");
  property p_out_red;
    settled && out_fault[0] && $past(out_fault[0]) |-> leds.out_led[1:0] == wdog_pkg::led_red;
  endproperty
  a_out_red: assert property (p_out_red) else $error("fault not red");
  property p_in_led; settled && $stable(in_state) |-> leds.in_led == in_state; endproperty
  a_in_led: assert property (p_in_led) else $error("input led wrong");
  property p_link;
    settled && $stable(port_link) |-> leds.port_link_indicator == port_link;
  endproperty
  a_link: assert property (p_link) else $error("link led wrong");
  property p_refuse;
    settled && switch_code == wdog_pkg::sw_ip_reset |-> !conn_allow && addr_clear;
  endproperty
  a_refuse: assert property (p_refuse) else $error("ip reset mode wrong");
  c_fail: cover property (settled && $rose(net_fail));
  c_clear: cover property (net_fail ##1 !net_fail);
  c_refuse: cover property (settled && !conn_allow);
endmodule

bind output_watchdog output_watchdog_checker chk_u (
  .clock, .reset, .switch_code, .cfg_read, .cfg_addr, .cfg_rdata, .auto_ack,
  .out_write, .out_data, .conn_timeout, .addr_write_req, .out_fault, .in_state,
  .port_link, .out_drive, .net_fail, .conn_allow, .addr_clear, .addr_write_allow, .leds,
  .status
);

//--- sim/client_model.sv
// Network client model: writes output process data and issues reads.
// Driven by task calls from the testbench; one clock.
`timescale 1ns/1ps
module client_model (
  input wire logic clock, // System clock
  output logic out_write, // Output write pulse
  output logic [3:0] out_data, // Output data
  output logic out_read // Read pulse
);
  initial begin
    out_write = 1'b0;
    out_data = 4'h0;
    out_read = 1'b0;
  end
  // Writes come far inside the timeout, so each restarts the count
  task automatic write_out(input logic [3:0] value);
    @(posedge clock);
    out_write <= 1'b1;
    out_data <= value;
    @(posedge clock);
    out_write <= 1'b0;
    // Released data inverted so a stale value never matches
    out_data <= ~value;
  endtask
  task automatic read_in();
    @(posedge clock);
    out_read <= 1'b1;
    @(posedge clock);
    out_read <= 1'b0;
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the output watchdog block.
// Drives config, status and fault inputs; a client model writes outputs.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] switch_code = 8'h00;
  logic factory_done = 1'b0;
  logic cfg_write = 1'b0;
  logic [1:0] cfg_addr = 2'h0;
  logic [15:0] cfg_data = 16'h0000;
  logic cfg_read = 1'b0;
  logic auto_ack = 1'b1;
  logic conn_timeout = 1'b0;
  logic addr_write_req = 1'b0;
  logic [3:0] out_fault = 4'h0;
  logic [7:0] in_state = 8'h00;
  logic [1:0] port_link = 2'h0;
  logic [1:0] port_activity = 2'h0;
  wdog_pkg::device_status_type status = '0;
  logic [15:0] cfg_rdata;
  logic out_write, out_read, net_fail, conn_allow, addr_clear, settings_restore;
  logic request_addressing, addr_write_allow, keep_settings;
  logic [3:0] out_data, out_drive;
  wdog_pkg::led_type leds;
  int num_errors = 0;
  int n_checks = 0;
  always #2.5 clock = ~clock;
  output_watchdog dut_u (
    .clock, .reset, .switch_code, .factory_done, .cfg_write, .cfg_addr, .cfg_data,
    .cfg_read, .cfg_rdata, .auto_ack, .out_write, .out_data, .out_read, .conn_timeout,
    .addr_write_req, .out_fault, .in_state, .port_link, .port_activity, .status,
    .out_drive, .net_fail, .conn_allow, .addr_clear, .settings_restore,
    .request_addressing, .addr_write_allow, .keep_settings, .leds
  );
  client_model client_u (.clock, .out_write, .out_data, .out_read);
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic [7:0] sw);
    @(posedge clock);
    reset <= 1'b1;
    switch_code <= sw;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    settle(3);
  endtask
  task automatic cfg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask
  task automatic cfg_rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1;
    check(cfg_rdata, exp);
  endtask
  task automatic lose_conn();
    @(posedge clock);
    conn_timeout <= 1'b1;
    @(posedge clock);
    conn_timeout <= 1'b0;
    #1;
  endtask
  task automatic sc_config();
    cfg_rd(2'h0, 16'h0000);
    cfg_wr(2'h0, 16'h00c7);
    cfg_rd(2'h0, 16'h0000);
    cfg_wr(2'h0, 16'hfde9);
    cfg_rd(2'h0, 16'h0000);
    cfg_wr(2'h0, 16'h00c8);
    cfg_rd(2'h0, 16'h00c8);
    cfg_wr(2'h0, 16'hfde8);
    cfg_rd(2'h0, 16'hfde8);
  endtask
  task automatic sc_fail();
    logic [3:0] exp [3] = '{4'h0, 4'hf, 4'ha};
    // Network indicator is blank while not ready
    @(posedge clock);
    status.ready <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      cfg_wr(2'h1, 16'(c));
      client_u.write_out(4'ha);
      #1;
      check(16'(out_drive), 16'ha);
      lose_conn();
      check(16'(net_fail), 16'h1);
      check(16'(out_drive), 16'(exp[c]));
      cfg_rd(2'h3, 16'h0002);
      check(16'(leds.net_led), 16'(wdog_pkg::led_red));
      client_u.read_in();
      #1;
      check(16'(net_fail), 16'h1);
      client_u.write_out(4'h5);
      #1;
      check(16'(net_fail), 16'h0);
      check(16'(out_drive), 16'h5);
    end
  endtask
  task automatic sc_manual();
    @(posedge clock);
    auto_ack <= 1'b0;
    cfg_wr(2'h1, 16'h0000);
    lose_conn();
    client_u.write_out(4'h6);
    #1;
    check(16'(net_fail), 16'h1);
    check(16'(out_drive), 16'h0);
    cfg_wr(2'h2, 16'h0001);
    #1;
    check(16'(net_fail), 16'h0);
    check(16'(out_drive), 16'h6);
    @(posedge clock);
    auto_ack <= 1'b1;
  endtask
  task automatic sc_leds();
    @(posedge clock);
    out_fault <= 4'h1;
    in_state <= 8'ha5;
    port_link <= 2'h2;
    port_activity <= 2'h1;
    status.ready <= 1'b1;
    status.conn_open <= 1'b1;
    status.sensor_present <= 1'b1;
    status.actuator_present <= 1'b1;
    settle(3);
    // Outputs hold 6: channel 0 faulted, channels 1 and 2 set
    check(16'(leds.out_led), 16'h2b);
    check(16'(leds.in_led), 16'ha5);
    check(16'(leds.port_link_indicator), 16'h2);
    check(16'(leds.port_activity_indicator), 16'h1);
    check(16'(leds.net_led), 16'(wdog_pkg::led_green));
    check(16'(leds.ready_led), 16'(wdog_pkg::led_green));
    check(16'(leds.sensor_supply_indicator), 16'(wdog_pkg::led_green));
    check(16'(leds.actuator_supply_indicator), 16'h1);
    @(posedge clock);
    status.sensor_overload <= 1'b1;
    status.conn_open <= 1'b0;
    status.addr_invalid <= 1'b1;
    settle(3);
    check(16'(leds.sensor_supply_indicator), 16'(wdog_pkg::led_red));
    check(16'(leds.net_led), 16'(wdog_pkg::led_yellow));
    @(posedge clock);
    status <= '0;
    settle(3);
    check(16'(leds.ready_led), 16'(wdog_pkg::led_off));
    check(16'(leds.net_led), 16'(wdog_pkg::led_off));
  endtask
  task automatic sc_switch();
    @(posedge clock);
    status.ready <= 1'b1;
    // Missing actuator supply would make ready flash instead of green
    status.actuator_present <= 1'b1;
    addr_write_req <= 1'b1;
    settle(2);
    check(16'(addr_write_allow), 16'h1);
    do_reset(wdog_pkg::sw_static);
    check(16'(addr_write_allow), 16'h0);
    do_reset(wdog_pkg::sw_ip_reset);
    check(16'({conn_allow, addr_clear, request_addressing}), 16'h3);
    check(16'(leds.net_led), 16'(wdog_pkg::led_yellow));
    do_reset(wdog_pkg::sw_factory);
    check(16'({conn_allow, settings_restore}), 16'h1);
    @(posedge clock);
    factory_done <= 1'b1;
    settle(2);
    check(16'(leds.ready_led), 16'(wdog_pkg::led_green));
    do_reset(8'h0b);
    check(16'(keep_settings), 16'h1);
    check(16'(leds.ready_led), 16'(wdog_pkg::led_red));
    cfg_rd(2'h0, 16'h0000);
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    final_report();
  end
  initial begin
    do_reset(8'h00);
    sc_config();
    sc_fail();
    sc_manual();
    sc_leds();
    sc_switch();
    final_report();
  end
endmodule
